//--- dii_pkg.sv
package dii_pkg;
  // Injected instruction words and their fields
  localparam logic [31:0] NOP_WORD   = 32'he1a00000;
  localparam logic [31:0] STR_BASE   = 32'he58e0000;
  localparam logic [31:0] LDR_BASE   = 32'he59e0000;
  localparam logic [31:0] MEMLD_WORD = 32'he4901004;
  localparam logic [31:0] MRS_WORD   = 32'he10f0000;
  localparam logic [31:0] RD_MASK    = 32'hffff0fff;
  localparam int          RD_LSB     = 12;
  localparam int          RD_MSB     = 15;
  localparam logic [3:0]  REG_R0     = 4'h0;
  localparam logic [3:0]  REG_R1     = 4'h1;
  localparam logic [3:0]  REG_PC     = 4'hf;
  localparam logic [31:0] MEM_STEP   = 32'h00000004;
  localparam logic [31:0] CPSR_RESET = 32'h00000000;

  // Test instruction register codes and scan chain numbers
  localparam int          IR_W         = 4;
  localparam logic [3:0]  IR_SCAN_N    = 4'h2;
  localparam logic [3:0]  IR_RESTART   = 4'h4;
  localparam logic [3:0]  IR_INTEST    = 4'hc;
  localparam logic [3:0]  IR_BYPASS    = 4'hf;
  localparam logic [3:0]  IR_CAPTURE   = 4'h1;
  localparam logic [3:0]  CHAIN_DEBUG  = 4'h1;
  localparam logic [3:0]  CHAIN_STATUS = 4'h2;
  localparam int          CHAIN_W      = 33;
  localparam int          BKPT_BIT     = 32;
  localparam int          LEN_SEL      = 4;
  localparam int          LEN_DEBUG    = 33;
  localparam int          LEN_STATUS   = 32;
  localparam int          LEN_BYPASS   = 1;

  // APB register map, byte addresses
  localparam logic [7:0]  ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_STATUS = 8'h04;
  localparam logic [7:0]  ADDR_DBUS   = 8'h08;
  localparam logic [7:0]  ADDR_CPSR   = 8'h0c;
  localparam int          CTRL_HALT   = 0;
  localparam int          STAT_ACK    = 0;
  localparam int          STAT_MREQ   = 1;
  localparam int          STAT_RUN    = 2;

  typedef enum {TAP_TLR, TAP_RTI, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PA_DR, TAP_EX2_DR,
                TAP_UP_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PA_IR, TAP_EX2_IR,
                TAP_UP_IR} dii_tap_type;
  typedef enum {CORE_RUN, CORE_DEBUG, CORE_SYS_ADDR, CORE_SYS_REQ, CORE_SYS_WAIT, CORE_SYS_INC} dii_core_type;
  typedef enum {P_NONE, P_STR, P_LDD, P_LDW, P_PC1, P_PC2} dii_pend_type;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } dii_jtag_type;

  typedef struct packed {
    logic        req;
    logic [31:0] addr;
  } dii_mem_req_type;
endpackage : dii_pkg

//--- dii_core_regs.sv
`timescale 1ns/100ps
module dii_core_regs (
  input  wire logic        i_mclk,
  input  wire logic        i_srst,
  input  wire logic        i_we,
  input  wire logic [3:0]  i_waddr,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_raddr,
  output logic      [31:0] o_rdata
);
  logic [31:0] mem [16];

  always_ff @(posedge i_mclk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    if (i_srst) begin
      o_rdata <= 32'h00000000;
    end else begin
      o_rdata <= mem[i_raddr];
    end
  end
endmodule : dii_core_regs

//--- dii_debug_inject.sv
`timescale 1ns/100ps
// Behaviour
// - Filler word 0xE1A00000 advances the pipeline without side effects.
// - Word enters pipeline at Run-Test/Idle step pulse; executes two words later.
// - Store drives selected register onto data bus in its fourth cycle.
// - Load writes supplied data into the register in cycle five.
// - Non-memory operations run entirely on debug step pulses.
// - Restart instruction runs the memory load that follows the tagged word on the main clock.
// - After system-speed work the core re-enters debug and sets both flags.
module dii_debug_inject (
  input  wire logic                     i_mclk,
  input  wire logic                     i_srst,
  input  wire dii_pkg::dii_jtag_type    i_jtag,
  output logic                          o_tdo,
  output logic                          o_tdo_en,
  input  wire logic                     i_psel,
  input  wire logic                     i_penable,
  input  wire logic                     i_pwrite,
  input  wire logic [7:0]               i_paddr,
  input  wire logic [31:0]              i_pwdata,
  output logic      [31:0]              o_prdata,
  output logic                          o_pready,
  output logic                          o_pslverr,
  output dii_pkg::dii_mem_req_type      o_mem,
  input  wire logic                     i_mem_ack,
  input  wire logic [31:0]              i_mem_rdata,
  output logic                          o_debug_ack_flag,
  output logic                          o_mem_request_low_flag,
  output logic                          o_debug_step_clock
);
  import dii_pkg::*;

  dii_jtag_type            sync1, sync2, sync3;
  dii_tap_type             tap, next_tap;
  logic [IR_W-1:0]         ir, next_ir, ir_sh, next_ir_sh;
  logic [3:0]              chain, next_chain;
  logic [CHAIN_W-1:0]      dr, next_dr;
  logic [31:0]             inj_word, next_inj_word;
  logic                    inj_bkpt, next_inj_bkpt;
  logic                    tdo, next_tdo, tdo_en, next_tdo_en;
  logic                    tck_rise, tck_fall, step, restart;
  int                      dr_len;
  dii_core_type            core, next_core;
  dii_pend_type            pend, next_pend;
  logic [31:0]             fetch, next_fetch, decode, next_decode;
  logic [31:0]             dbus, next_dbus, ld_data, next_ld_data;
  logic [31:0]             sys_word, next_sys_word, cpsr, next_cpsr;
  logic [3:0]              rd_sel, next_rd_sel, rf_raddr, rf_waddr;
  logic                    sys_armed, next_sys_armed, sys_valid, next_sys_valid;
  logic                    ack, next_ack, mreq_low, next_mreq_low;
  dii_mem_req_type         mem, next_mem;
  logic                    rf_we;
  logic [31:0]             rf_wdata, rf_rdata, prdata, next_prdata;
  logic                    apb_wr, apb_setup, mapped;

  // Pins come from the link clock domain: two flops, then edge detect on later stages
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= i_jtag;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end
  assign tck_rise = sync2.tck & ~sync3.tck;
  assign tck_fall = ~sync2.tck & sync3.tck;

  // Step pulse on entry to Run-Test/Idle while the debug chain is selected
  assign step    = tck_rise && (tap != TAP_RTI) && (next_tap == TAP_RTI) && (ir == IR_INTEST)
                   && (chain == CHAIN_DEBUG);
  assign restart = tck_rise && (tap != TAP_RTI) && (next_tap == TAP_RTI) && (ir == IR_RESTART);
  assign o_debug_step_clock = step;

  always_comb begin
    case (tap)
      TAP_TLR:    next_tap = sync2.tms ? TAP_TLR : TAP_RTI;
      TAP_RTI:    next_tap = sync2.tms ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_DR: next_tap = sync2.tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: next_tap = sync2.tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:  next_tap = sync2.tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: next_tap = sync2.tms ? TAP_UP_DR : TAP_PA_DR;
      TAP_PA_DR:  next_tap = sync2.tms ? TAP_EX2_DR : TAP_PA_DR;
      TAP_EX2_DR: next_tap = sync2.tms ? TAP_UP_DR : TAP_SH_DR;
      TAP_UP_DR:  next_tap = sync2.tms ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_IR: next_tap = sync2.tms ? TAP_TLR : TAP_CAP_IR;
      TAP_CAP_IR: next_tap = sync2.tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:  next_tap = sync2.tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: next_tap = sync2.tms ? TAP_UP_IR : TAP_PA_IR;
      TAP_PA_IR:  next_tap = sync2.tms ? TAP_EX2_IR : TAP_PA_IR;
      TAP_EX2_IR: next_tap = sync2.tms ? TAP_UP_IR : TAP_SH_IR;
      TAP_UP_IR:  next_tap = sync2.tms ? TAP_SEL_DR : TAP_RTI;
      default:    next_tap = TAP_TLR;
    endcase
  end

  // Scan path: one shift register serves every data chain, its length set by the selection
  always_comb begin
    next_ir       = ir;
    next_ir_sh    = ir_sh;
    next_chain    = chain;
    next_dr       = dr;
    next_inj_word = inj_word;
    next_inj_bkpt = inj_bkpt;
    next_tdo      = tdo;
    next_tdo_en   = tdo_en;
    if (ir == IR_SCAN_N) begin
      dr_len = LEN_SEL;
    end else if (ir == IR_INTEST && chain == CHAIN_DEBUG) begin
      dr_len = LEN_DEBUG;
    end else if (ir == IR_INTEST && chain == CHAIN_STATUS) begin
      dr_len = LEN_STATUS;
    end else begin
      dr_len = LEN_BYPASS;
    end
    if (tck_rise) begin
      case (tap)
        TAP_TLR: begin
          next_ir = IR_BYPASS;
        end
        TAP_CAP_DR: begin
          next_dr = '0;
          if (ir == IR_INTEST && chain == CHAIN_DEBUG) begin
            next_dr[31:0] = dbus;
          end else if (ir == IR_INTEST && chain == CHAIN_STATUS) begin
            next_dr[STAT_ACK]  = ack;
            next_dr[STAT_MREQ] = mreq_low;
          end
        end
        TAP_SH_DR: begin
          next_dr             = dr >> 1;
          next_dr[dr_len - 1] = sync2.tdi;
        end
        TAP_CAP_IR: next_ir_sh = IR_CAPTURE;
        TAP_SH_IR:  next_ir_sh = {sync2.tdi, ir_sh[IR_W-1:1]};
        default: begin
        end
      endcase
    end
    // Output changes on the falling test clock, as the far end samples on the rise
    if (tck_fall) begin
      next_tdo_en = (tap == TAP_SH_DR) || (tap == TAP_SH_IR);
      next_tdo    = (tap == TAP_SH_IR) ? ir_sh[0] : dr[0];
      // Updates land on the fall, so the step or restart on the next rise sees the new word and code
      if (tap == TAP_UP_DR && ir == IR_SCAN_N) begin
        next_chain = dr[3:0];
      end else if (tap == TAP_UP_DR && ir == IR_INTEST && chain == CHAIN_DEBUG) begin
        next_inj_word = dr[31:0];
        next_inj_bkpt = dr[BKPT_BIT];
      end else if (tap == TAP_UP_IR) begin
        next_ir = ir_sh;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      tap      <= TAP_TLR;
      ir       <= IR_BYPASS;
      ir_sh    <= '0;
      chain    <= '0;
      dr       <= '0;
      inj_word <= NOP_WORD;
      inj_bkpt <= 1'b0;
      tdo      <= 1'b0;
      tdo_en   <= 1'b0;
    end else begin
      tap      <= tck_rise ? next_tap : tap;
      ir       <= next_ir;
      ir_sh    <= next_ir_sh;
      chain    <= next_chain;
      dr       <= next_dr;
      inj_word <= next_inj_word;
      inj_bkpt <= next_inj_bkpt;
      tdo      <= next_tdo;
      tdo_en   <= next_tdo_en;
    end
  end
  assign o_tdo    = tdo;
  assign o_tdo_en = tdo_en;

  // Core: pipeline advances only on step pulses; multi-cycle ops stall fetch and decode
  assign rf_raddr = (core == CORE_SYS_ADDR || core == CORE_SYS_REQ) ? REG_R0 :
                    (pend != P_NONE) ? rd_sel : decode[RD_MSB:RD_LSB];

  always_comb begin
    next_core      = core;
    next_pend      = pend;
    next_fetch     = fetch;
    next_decode    = decode;
    next_dbus      = dbus;
    next_ld_data   = ld_data;
    next_rd_sel    = rd_sel;
    next_sys_word  = sys_word;
    next_sys_armed = sys_armed;
    next_sys_valid = sys_valid;
    next_cpsr      = cpsr;
    next_mem       = mem;
    rf_we          = 1'b0;
    rf_waddr       = rd_sel;
    rf_wdata       = ld_data;
    if (apb_wr && i_paddr == ADDR_CPSR) begin
      next_cpsr = i_pwdata;
    end
    case (core)
      CORE_RUN: begin
        if (apb_wr && i_paddr == ADDR_CTRL && i_pwdata[CTRL_HALT]) begin
          next_core = CORE_DEBUG;
        end
      end
      CORE_DEBUG: begin
        if (restart) begin
          next_sys_valid = 1'b0;
          next_core = (sys_valid && sys_word == MEMLD_WORD) ? CORE_SYS_ADDR : CORE_RUN;
        end else if (step) begin
          case (pend)
            P_NONE: begin
              next_fetch  = inj_word;
              next_decode = fetch;
              // A tagged word marks the following instruction for system speed
              if (inj_bkpt) begin
                next_sys_armed = 1'b1;
              end else if (sys_armed) begin
                next_sys_word  = inj_word;
                next_sys_valid = 1'b1;
                next_sys_armed = 1'b0;
              end
              // Decode word is the one entering execute on this pulse
              if ((decode & RD_MASK) == STR_BASE) begin
                next_pend   = P_STR;
                next_rd_sel = decode[RD_MSB:RD_LSB];
              end else if ((decode & RD_MASK) == LDR_BASE) begin
                next_pend   = P_LDD;
                next_rd_sel = decode[RD_MSB:RD_LSB];
              end else if (decode == MRS_WORD) begin
                rf_we    = 1'b1;
                rf_waddr = REG_R0;
                rf_wdata = cpsr;
              end
            end
            P_STR: begin
              next_dbus = rf_rdata;
              next_pend = P_NONE;
            end
            P_LDD: begin
              next_ld_data = inj_word;
              next_pend    = P_LDW;
            end
            P_LDW: begin
              rf_we     = 1'b1;
              next_pend = (rd_sel == REG_PC) ? P_PC1 : P_NONE;
            end
            P_PC1: next_pend = P_PC2;
            P_PC2: begin
              next_pend   = P_NONE;
              next_fetch  = NOP_WORD;
              next_decode = NOP_WORD;
            end
            default: next_pend = P_NONE;
          endcase
        end
      end
      CORE_SYS_ADDR: next_core = CORE_SYS_REQ;
      CORE_SYS_REQ: begin
        next_mem.addr = rf_rdata;
        next_mem.req  = 1'b1;
        next_core     = CORE_SYS_WAIT;
      end
      CORE_SYS_WAIT: begin
        if (i_mem_ack) begin
          rf_we        = 1'b1;
          rf_waddr     = REG_R1;
          rf_wdata     = i_mem_rdata;
          next_mem.req = 1'b0;
          next_core    = CORE_SYS_INC;
        end
      end
      CORE_SYS_INC: begin
        rf_we       = 1'b1;
        rf_waddr    = REG_R0;
        rf_wdata    = mem.addr + MEM_STEP;
        next_core   = CORE_DEBUG;
        next_fetch  = NOP_WORD;
        next_decode = NOP_WORD;
      end
      default: next_core = CORE_RUN;
    endcase
    next_ack      = (next_core == CORE_DEBUG);
    next_mreq_low = ~next_mem.req;
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      core      <= CORE_RUN;
      pend      <= P_NONE;
      fetch     <= NOP_WORD;
      decode    <= NOP_WORD;
      dbus      <= '0;
      ld_data   <= '0;
      rd_sel    <= '0;
      sys_word  <= NOP_WORD;
      sys_armed <= 1'b0;
      sys_valid <= 1'b0;
      cpsr      <= CPSR_RESET;
      mem       <= '0;
      ack       <= 1'b0;
      mreq_low  <= 1'b1;
    end else begin
      core      <= next_core;
      pend      <= next_pend;
      fetch     <= next_fetch;
      decode    <= next_decode;
      dbus      <= next_dbus;
      ld_data   <= next_ld_data;
      rd_sel    <= next_rd_sel;
      sys_word  <= next_sys_word;
      sys_armed <= next_sys_armed;
      sys_valid <= next_sys_valid;
      cpsr      <= next_cpsr;
      mem       <= next_mem;
      ack       <= next_ack;
      mreq_low  <= next_mreq_low;
    end
  end
  assign o_mem                  = mem;
  assign o_debug_ack_flag       = ack;
  assign o_mem_request_low_flag = mreq_low;

  dii_core_regs u_regs (
    .i_mclk  (i_mclk),
    .i_srst  (i_srst),
    .i_we    (rf_we),
    .i_waddr (rf_waddr),
    .i_wdata (rf_wdata),
    .i_raddr (rf_raddr),
    .o_rdata (rf_rdata)
  );

  // APB: read data is registered in the setup cycle, so the access phase never waits
  assign apb_setup = i_psel & ~i_penable;
  assign apb_wr    = i_psel & i_penable & i_pwrite & mapped;
  assign mapped    = (i_paddr == ADDR_CTRL) || (i_paddr == ADDR_STATUS) || (i_paddr == ADDR_DBUS)
                     || (i_paddr == ADDR_CPSR);
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~mapped;

  always_comb begin
    next_prdata = prdata;
    if (apb_setup) begin
      next_prdata = '0;
      case (i_paddr)
        ADDR_STATUS: begin
          next_prdata[STAT_ACK]  = ack;
          next_prdata[STAT_MREQ] = mreq_low;
          next_prdata[STAT_RUN]  = (core == CORE_RUN);
        end
        ADDR_DBUS: next_prdata = dbus;
        ADDR_CPSR: next_prdata = cpsr;
        default:   next_prdata = '0;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      prdata <= '0;
    end else begin
      prdata <= next_prdata;
    end
  end
  assign o_prdata = prdata;
endmodule : dii_debug_inject

//--- dii_checker.sv
`timescale 1ns/100ps
module dii_checker (
  input wire logic                    i_mclk,
  input wire logic                    i_srst,
  input wire logic                    i_psel,
  input wire logic                    i_penable,
  input wire logic                    i_pwrite,
  input wire logic [7:0]              i_paddr,
  input wire logic [31:0]             i_pwdata,
  input wire logic                    o_pready,
  input wire logic                    o_pslverr,
  input wire dii_pkg::dii_mem_req_type o_mem,
  input wire logic                    i_mem_ack,
  input wire logic                    o_debug_ack_flag,
  input wire logic                    o_mem_request_low_flag,
  input wire logic                    o_debug_step_clock
);
  import dii_pkg::*;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  logic acc;
  logic mapped;
  assign acc    = i_psel && i_penable;
  assign mapped = i_paddr inside {ADDR_CTRL, ADDR_STATUS, ADDR_DBUS, ADDR_CPSR};

  a_ready_in_access: assert property (acc |-> o_pready)
    else $error("pready low in access phase");
  a_err_unmapped: assert property (acc |-> o_pslverr == !mapped)
    else $error("pslverr does not match address decode");
  a_err_only_access: assert property (!acc |-> !o_pslverr)
    else $error("pslverr outside access phase");
  a_step_single_pulse: assert property (o_debug_step_clock |=> !o_debug_step_clock)
    else $error("step pulse longer than one cycle");
  a_req_held: assert property (o_mem.req && !i_mem_ack |=> o_mem.req && $stable(o_mem.addr))
    else $error("memory request dropped or moved before ack");
  a_ack_ends_req: assert property (o_mem.req && i_mem_ack |=> !o_mem.req)
    else $error("memory request stays after ack");
  a_busy_flags_low: assert property (o_mem.req |-> !o_mem_request_low_flag && !o_debug_ack_flag)
    else $error("status flags set while memory request pending");
  a_debug_reentry: assert property (o_mem.req && i_mem_ack |-> ##[1:4] (o_debug_ack_flag && o_mem_request_low_flag))
    else $error("core did not re-enter debug after system access");
  a_halt_to_debug: assert property (acc && i_pwrite && i_paddr == ADDR_CTRL && i_pwdata[CTRL_HALT]
    && !o_mem.req && o_mem_request_low_flag |-> ##[1:2] o_debug_ack_flag)
    else $error("halt request did not reach debug state");

  c_step: cover property (o_debug_step_clock);
  c_mem_done: cover property (o_mem.req && i_mem_ack);
  c_err: cover property (acc && o_pslverr);
endmodule : dii_checker

bind dii_debug_inject dii_checker chk_u (
  .i_mclk(i_mclk), .i_srst(i_srst), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
  .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_mem(o_mem),
  .i_mem_ack(i_mem_ack), .o_debug_ack_flag(o_debug_ack_flag),
  .o_mem_request_low_flag(o_mem_request_low_flag), .o_debug_step_clock(o_debug_step_clock));

//--- dii_host_model.sv
`timescale 1ns/100ps
module dii_host_model (
  input  wire logic             i_mclk,
  input  wire logic             i_tdo,
  output dii_pkg::dii_jtag_type o_jtag
);
  import dii_pkg::*;
  // Data pin idles high as if pulled up; clock stands still between bits
  initial o_jtag = 3'b011;

  // One test clock period of eight core clocks; tdo is taken late in the high half
  task automatic tbit(input logic m, input logic d, output logic q);
    o_jtag.tck <= 1'b0;
    o_jtag.tms <= m;
    o_jtag.tdi <= d;
    repeat (4) @(posedge i_mclk);
    o_jtag.tck <= 1'b1;
    repeat (3) @(posedge i_mclk);
    @(negedge i_mclk);
    q = i_tdo;
    @(posedge i_mclk);
  endtask : tbit

  task automatic xfer(input logic ir, input logic [32:0] d, input int len, output logic [32:0] q);
    logic b;
    q = '0;
    tbit(1'b1, 1'b1, b);
    if (ir) tbit(1'b1, 1'b1, b);
    tbit(1'b0, 1'b1, b);
    tbit(1'b0, 1'b1, b);
    for (int i = 0; i < len; i++) begin
      tbit(i == len - 1, d[i], b);
      q[i] = b;
    end
    tbit(1'b1, 1'b1, b);
  endtask : xfer

  task automatic idle();
    logic b;
    tbit(1'b0, 1'b1, b);
  endtask : idle

  task automatic init();
    logic b;
    repeat (5) tbit(1'b1, 1'b1, b);
    tbit(1'b0, 1'b1, b);
  endtask : init

  // Ends in Update-IR so that no stray step hits the pipeline
  task automatic ir(input logic [3:0] c);
    logic [32:0] q;
    xfer(1'b1, {29'h0, c}, IR_W, q);
  endtask : ir

  task automatic sel_chain(input logic [3:0] ch);
    logic [32:0] q;
    ir(IR_SCAN_N);
    xfer(1'b0, {29'h0, ch}, LEN_SEL, q);
    ir(IR_INTEST);
  endtask : sel_chain

  task automatic inject(input logic [31:0] w, input logic tag, output logic [31:0] q);
    logic [32:0] c;
    xfer(1'b0, {tag, w}, LEN_DEBUG, c);
    idle();
    q = c[31:0];
  endtask : inject

  task automatic wr_reg(input logic [3:0] n, input logic [31:0] v);
    logic [31:0] q;
    inject({LDR_BASE[31:16], n, LDR_BASE[11:0]}, 1'b0, q);
    repeat (2) inject(NOP_WORD, 1'b0, q);
    inject(v, 1'b0, q);
    inject(NOP_WORD, 1'b0, q);
    if (n == REG_PC) repeat (2) inject(NOP_WORD, 1'b0, q);
  endtask : wr_reg

  // The last filler's capture returns the stored word
  task automatic rd_reg(input logic [3:0] n, output logic [31:0] q);
    inject({STR_BASE[31:16], n, STR_BASE[11:0]}, 1'b0, q);
    repeat (3) inject(NOP_WORD, 1'b0, q);
    inject(NOP_WORD, 1'b0, q);
  endtask : rd_reg
endmodule : dii_host_model

//--- tb_top.sv
`timescale 1ns/100ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_mismatch++; $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module tb_top;
  import dii_pkg::*;
  logic            mclk = 1'b0;
  logic            srst = 1'b1;
  logic            psel = 1'b0;
  logic            penable = 1'b0;
  logic            pwrite = 1'b0;
  logic [7:0]      paddr = '0;
  logic [31:0]     pwdata = '0;
  logic            mem_ack = 1'b0;
  logic [31:0]     mem_rdata = '0;
  logic [31:0]     mem_addr = '0;
  logic [31:0]     prdata;
  logic            pready, pslverr, tdo, tdo_en, ack_flag, mreq_low, step;
  dii_jtag_type    jtag;
  dii_mem_req_type mem;
  int              n_mismatch = 0;
  int              n_compared = 0;
  int              n_step = 0;
  int              n_cyc = 0;
  int              mem_wait = 0;

  always #25 mclk = ~mclk;

  dii_debug_inject dut_u (
    .i_mclk(mclk), .i_srst(srst), .i_jtag(jtag), .o_tdo(tdo), .o_tdo_en(tdo_en), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .o_mem(mem), .i_mem_ack(mem_ack), .i_mem_rdata(mem_rdata),
    .o_debug_ack_flag(ack_flag), .o_mem_request_low_flag(mreq_low), .o_debug_step_clock(step));
  dii_host_model host_u (.i_mclk(mclk), .i_tdo(tdo), .o_jtag(jtag));

  // Slow memory: answers after a wait; data toggles whenever it is not valid
  always @(posedge mclk) begin
    mem_wait  <= mem.req ? mem_wait + 1 : 0;
    mem_ack   <= mem.req && !mem_ack && mem_wait == 3;
    mem_rdata <= (mem.req && !mem_ack && mem_wait == 3) ? 32'hcafe_f00d : ~mem_rdata;
    if (mem.req) mem_addr <= mem.addr;
    if (step) n_step <= n_step + 1;
    n_cyc <= n_cyc + 1;
    if (n_cyc == 60000) begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic test_done();
    if (n_mismatch == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb

  task automatic t_reset();
    logic [31:0] r;
    logic        e;
    `CHK({ack_flag, mreq_low, mem.req, tdo_en, prdata}, {1'b0, 1'b1, 1'b0, 1'b0, 32'h0})
    apb(1'b0, ADDR_STATUS, 32'h0, r, e);
    `CHK(r, 32'h6)
    apb(1'b0, ADDR_CPSR, 32'h0, r, e);
    `CHK({e, r}, {1'b0, 32'h0})
    apb(1'b1, 8'h14, 32'hffff_ffff, r, e);
    `CHK(e, 1'b1)
    apb(1'b0, 8'h10, 32'h0, r, e);
    `CHK({e, r}, {1'b1, 32'h0})
  endtask : t_reset

  task automatic t_halt();
    logic [31:0] r;
    logic        e;
    apb(1'b1, ADDR_CTRL, 32'h1, r, e);
    apb(1'b0, ADDR_STATUS, 32'h0, r, e);
    `CHK(r, 32'h3)
    host_u.init();
    host_u.sel_chain(CHAIN_DEBUG);
  endtask : t_halt

  task automatic t_regs();
    logic [3:0]  idx [3] = '{4'h0, 4'h7, 4'he};
    logic [31:0] val [3] = '{32'h0f1e_2d3c, 32'h8796_a5b4, 32'h1122_3344};
    logic [31:0] r;
    logic        e;
    int          s;
    s = n_step;
    host_u.wr_reg(idx[0], val[0]);
    `CHK(n_step - s, 5)
    for (int i = 1; i < 3; i++) host_u.wr_reg(idx[i], val[i]);
    host_u.wr_reg(REG_PC, 32'h0000_0200);
    for (int i = 0; i < 3; i++) begin
      host_u.rd_reg(idx[i], r);
      `CHK(r, val[i])
    end
    apb(1'b0, ADDR_DBUS, 32'h0, r, e);
    `CHK(r, val[2])
  endtask : t_regs

  task automatic t_cpsr();
    logic [31:0] r;
    logic        e;
    apb(1'b1, ADDR_CPSR, 32'h0000_00d3, r, e);
    apb(1'b0, ADDR_CPSR, 32'h0, r, e);
    `CHK(r, 32'h0000_00d3)
    host_u.inject(MRS_WORD, 1'b0, r);
    repeat (2) host_u.inject(NOP_WORD, 1'b0, r);
    host_u.rd_reg(REG_R0, r);
    `CHK(r, 32'h0000_00d3)
  endtask : t_cpsr

  task automatic t_mem();
    logic [31:0] r;
    logic        e;
    int          k;
    `CHK(mem_addr, 32'h0)
    host_u.wr_reg(REG_R0, 32'h0000_1000);
    host_u.inject(NOP_WORD, 1'b0, r);
    host_u.inject(NOP_WORD, 1'b1, r);
    host_u.inject(MEMLD_WORD, 1'b0, r);
    host_u.inject(NOP_WORD, 1'b0, r);
    host_u.ir(IR_RESTART);
    host_u.idle();
    k = 0;
    r = '0;
    while (r !== 32'h3 && k < 200) begin
      apb(1'b0, ADDR_STATUS, 32'h0, r, e);
      k++;
    end
    `CHK(r, 32'h3)
    `CHK(mem_addr, 32'h0000_1000)
    host_u.sel_chain(CHAIN_DEBUG);
    host_u.rd_reg(REG_R1, r);
    `CHK(r, 32'hcafe_f00d)
    host_u.rd_reg(REG_R0, r);
    `CHK(r, 32'h0000_1004)
    host_u.wr_reg(REG_R0, 32'h0f1e_2d3c);
  endtask : t_mem

  initial begin
    repeat (12) @(posedge mclk);
    srst <= 1'b0;
    repeat (2) @(posedge mclk);
    t_reset();
    t_halt();
    t_regs();
    t_cpsr();
    t_mem();
    test_done();
  end
endmodule : tb_top
